/* src/pbc_loader.sv */
`default_nettype none
// holds eeprom-loadable defaults; a load pulse while i_ce is high replaces them
module pbc_loader (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_ce,
    input  wire logic                 i_load,
    input  wire logic [7:0]           i_base_power,
    input  wire logic                 i_sys_alloc,
    output logic [7:0]                o_base_power,
    output logic                      o_sys_alloc
);
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_base_power <= pbc_pkg::BASE_POWER_RESET;
        end else if (i_ce && i_load) begin
            o_base_power <= i_base_power;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sys_alloc <= pbc_pkg::SYS_ALLOC_RESET;
        end else if (i_ce && i_load) begin
            o_sys_alloc <= i_sys_alloc;
        end
    end
endmodule : pbc_loader
`default_nettype wire

/* src/pbc_pkg.sv */
`default_nettype none
package pbc_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_HEADER = 12'h20c;
    localparam logic [11:0] OFS_INDEX  = 12'h210;
    localparam logic [11:0] OFS_DATA   = 12'h214;
    localparam logic [11:0] OFS_SYSFLG = 12'h218;

    // header fields
    localparam logic [15:0] CAP_ID        = 16'h0004;
    localparam logic [3:0]  CAP_VERSION   = 4'h1;
    localparam logic [11:0] NEXT_PTR_UP   = 12'h230;
    localparam logic [11:0] NEXT_PTR_DOWN = 12'h220;

    // index reset and supported selectors
    localparam logic [7:0] INDEX_RESET   = 8'h00;
    localparam logic [7:0] SEL_D0_MAX    = 8'h00;
    localparam logic [7:0] SEL_D0_SUSTAIN = 8'h01;

    // record field defaults
    localparam logic [7:0] BASE_POWER_RESET = 8'h04;
    localparam logic [1:0] SCALE_RESET      = 2'h0;
    localparam logic [2:0] SUBSTATE_RESET   = 3'h0;
    localparam logic [1:0] PM_STATE_RESET   = 2'h0;
    localparam logic [2:0] TYPE_MAX         = 3'h7;
    localparam logic [2:0] RAIL_RESET       = 3'h2;
    localparam logic       SYS_ALLOC_RESET  = 1'b0;

    // one budget record, bits 20:0 of the data register
    typedef struct packed {
        logic [2:0] rail;
        logic [2:0] cond_type;
        logic [1:0] pm_state;
        logic [2:0] substate;
        logic [1:0] scale;
        logic [7:0] base_power;
    } pbc_record_s;

    localparam pbc_record_s RECORD_RESET = '{
        rail:       RAIL_RESET,
        cond_type:  TYPE_MAX,
        pm_state:   PM_STATE_RESET,
        substate:   SUBSTATE_RESET,
        scale:      SCALE_RESET,
        base_power: BASE_POWER_RESET
    };

    // classic wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } pbc_wb_req_s;

    typedef enum logic [1:0] {
        PBC_IDLE = 2'b00,
        PBC_ACK  = 2'b01
    } pbc_wb_state_e;
endpackage : pbc_pkg
`default_nettype wire

/* src/pbc_record_mux.sv */
`default_nettype none
// picks the record presented for the current selector
module pbc_record_mux (
    input  wire logic [7:0]            i_select,
    input  wire logic [7:0]            i_base_power,
    output pbc_pkg::pbc_record_s       o_record
);
    pbc_pkg::pbc_record_s rec;

    always_comb begin
        rec = pbc_pkg::RECORD_RESET;
        rec.base_power = i_base_power;
        if (i_select == pbc_pkg::SEL_D0_MAX || i_select == pbc_pkg::SEL_D0_SUSTAIN) begin
            o_record = rec;
        end else begin
            o_record = '0;
        end
    end
endmodule : pbc_record_mux
`default_nettype wire

/* src/pbc_regs.sv */
`default_nettype none
module pbc_regs #(
    parameter logic IS_UPSTREAM = 1'b1
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_ce,
    input  wire logic                 i_wb_cyc,
    input  wire logic                 i_wb_stb,
    input  wire logic                 i_wb_we,
    input  wire logic [3:0]           i_wb_sel,
    input  wire logic [11:0]          i_wb_adr,
    input  wire logic [31:0]          i_wb_dat,
    input  wire logic                 i_ee_load,
    input  wire logic [7:0]           i_ee_base_power,
    input  wire logic                 i_ee_sys_alloc,
    output logic [31:0]               o_wb_dat,
    output logic                      o_wb_ack,
    output logic [7:0]                o_select
);
    pbc_pkg::pbc_wb_req_s  req;
    pbc_pkg::pbc_wb_state_e state_r;
    pbc_pkg::pbc_record_s  record;
    logic [7:0]            select_r;
    logic [7:0]            base_power;
    logic                  sys_alloc;
    logic [31:0]           rd_nxt;
    logic                  access;

    assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we,
                   sel: i_wb_sel, adr: i_wb_adr, dat: i_wb_dat};
    assign access = req.cyc && req.stb && (state_r == pbc_pkg::PBC_IDLE);

    pbc_loader u_loader (
        .i_ref_clk    (i_ref_clk),
        .i_rst_n      (i_rst_n),
        .i_ce         (i_ce),
        .i_load       (i_ee_load),
        .i_base_power (i_ee_base_power),
        .i_sys_alloc  (i_ee_sys_alloc),
        .o_base_power (base_power),
        .o_sys_alloc  (sys_alloc)
    );

    // selector decoded combinationally so a read right after a write sees it
    pbc_record_mux u_mux (
        .i_select     (select_r),
        .i_base_power (base_power),
        .o_record     (record)
    );

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (req.adr)
            pbc_pkg::OFS_HEADER: begin
                rd_nxt[15:0]  = pbc_pkg::CAP_ID;
                rd_nxt[19:16] = pbc_pkg::CAP_VERSION;
                rd_nxt[31:20] = IS_UPSTREAM ? pbc_pkg::NEXT_PTR_UP
                                            : pbc_pkg::NEXT_PTR_DOWN;
            end
            pbc_pkg::OFS_INDEX: begin
                rd_nxt[7:0] = select_r;
            end
            pbc_pkg::OFS_DATA: begin
                // fields ..live in the record layout
                rd_nxt[20:0] = record;
            end
            pbc_pkg::OFS_SYSFLG: begin
                rd_nxt[0] = sys_alloc;
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    // only byte lane 0 carries writable bits
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            select_r <= pbc_pkg::INDEX_RESET;
        end else if (i_ce && access && req.we && req.sel[0]
                     && req.adr == pbc_pkg::OFS_INDEX) begin
            select_r <= req.dat[7:0];
        end
    end

    // one wait-free answer per request, then one idle cycle so ack drops
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r  <= pbc_pkg::PBC_IDLE;
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else if (i_ce) begin
            case (state_r)
                pbc_pkg::PBC_IDLE: begin
                    if (access) begin
                        state_r  <= pbc_pkg::PBC_ACK;
                        o_wb_ack <= 1'b1;
                        o_wb_dat <= req.we ? 32'h0000_0000 : rd_nxt;
                    end
                end
                pbc_pkg::PBC_ACK: begin
                    state_r  <= pbc_pkg::PBC_IDLE;
                    o_wb_ack <= 1'b0;
                end
                default: begin
                    state_r  <= pbc_pkg::PBC_IDLE;
                    o_wb_ack <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_select <= pbc_pkg::INDEX_RESET;
        end else if (i_ce) begin
            o_select <= select_r;
        end
    end
endmodule : pbc_regs
`default_nettype wire

/* test/pbc_regs_monitor.sv */
`default_nettype none
module pbc_regs_monitor #(
    parameter logic IS_UPSTREAM = 1'b1
) (
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic [7:0]  o_select
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // request counts as taken only while the slave is idle
    sequence s_req;
        i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_rd(logic [11:0] a);
        s_req ##0 (!i_wb_we && i_wb_adr == a);
    endsequence
    sequence s_wr;
        s_req ##0 i_wb_we;
    endsequence
    property p_ack;
        s_req |=> o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");
    property p_hdr;
        s_rd(12'h20c) |=> o_wb_dat == {(IS_UPSTREAM ? 12'h230 : 12'h220), 4'h1, 16'h0004};
    endproperty
    a_hdr: assert property (p_hdr) else $error("header wrong");
    property p_dsup;
        s_rd(12'h214) ##0 (o_select < 8'h02) |=> o_wb_dat[31:8] == 24'h000b80;
    endproperty
    a_dsup: assert property (p_dsup) else $error("record fields wrong");
    property p_dzero;
        s_rd(12'h214) ##0 (o_select > 8'h01) |=> o_wb_dat == 32'h0;
    endproperty
    a_dzero: assert property (p_dzero) else $error("unsupported record not zero");
    property p_idx;
        s_rd(12'h210) |=> o_wb_dat == {24'h0, o_select};
    endproperty
    a_idx: assert property (p_idx) else $error("index read wrong");
    property p_flag;
        s_rd(12'h218) |=> o_wb_dat[31:1] == 31'h0;
    endproperty
    a_flag: assert property (p_flag) else $error("flag reserved bits set");
    property p_ro;
        s_wr ##0 (i_wb_adr != 12'h210) |=> $stable(o_select)[*2];
    endproperty
    a_ro: assert property (p_ro) else $error("selector moved on other write");
    property p_wdat;
        s_wr |=> o_wb_dat == 32'h0;
    endproperty
    a_wdat: assert property (p_wdat) else $error("write returned data");
endmodule : pbc_regs_monitor
bind pbc_regs pbc_regs_monitor #(.IS_UPSTREAM(IS_UPSTREAM)) mon_u (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .o_select(o_select));
`default_nettype wire

/* test/power_budget_capability_tb_top.sv */
`default_nettype none
module power_budget_capability_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_ref_clk, i_rst_n, cyc, we, ld, sa, ack, ce;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] wd, rd, q, lf, rd_dn, qd;
    logic [7:0]  bp, v, osel;
    logic [11:0] ro [4] = '{12'h20c, 12'h214, 12'h218, 12'h2fc};
    logic [7:0]  cv [4] = '{8'h02, 8'hff, 8'h01, 8'h00};
    int          fail_count = 0;
    int          total_checks = 0;
    pbc_regs #(.IS_UPSTREAM(1'b1)) dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_sel(sel),
        .i_wb_adr(adr), .i_wb_dat(wd), .i_ee_load(ld), .i_ee_base_power(bp),
        .i_ee_sys_alloc(sa), .o_wb_dat(rd), .o_wb_ack(ack), .o_select(osel));
    // downstream twin on the same bus, only its header pointer differs
    pbc_regs #(.IS_UPSTREAM(1'b0)) dut_dn_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_sel(sel),
        .i_wb_adr(adr), .i_wb_dat(wd), .i_ee_load(ld), .i_ee_base_power(bp),
        .i_ee_sys_alloc(sa), .o_wb_dat(rd_dn), .o_wb_ack(), .o_select());
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    function automatic logic [31:0] exp_data(input logic [7:0] s, input logic [7:0] b);
        return (s > 8'h01) ? 32'h0 : {11'h0, 3'h2, 3'h7, 2'h0, 3'h0, 2'h0, b};
    endfunction : exp_data
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // ack and data taken at the rising edge; holding longer would be taken twice
    task automatic wb(input logic [11:0] a, input logic w, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        cyc <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        wd <= d;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            fail_count++;
            tally_and_finish();
        end
        q = rd;
        qd = rd_dn;
        cyc <= 1'b0;
    endtask : wb
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        wb(a, 1'b0, 4'hf, 32'h0);
        chk(q, e);
    endtask : rc
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        {i_rst_n, cyc, we, ld, sa, sel, adr, wd, bp} = '0;
        ce = 1'b1;
        lf = 32'h3d5d7174;
        repeat (16) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rc(12'h20c, 32'h2301_0004);
        chk(qd, 32'h2201_0004);
        rc(12'h210, 32'h0);
        rc(12'h214, 32'h000b_8004);
        rc(12'h218, 32'h0);
        $display("test reset done");
        foreach (ro[i]) begin
            lf = nxt(lf);
            wb(ro[i], 1'b1, 4'hf, lf);
        end
        rc(12'h20c, 32'h2301_0004);
        rc(12'h214, 32'h000b_8004);
        rc(12'h218, 32'h0);
        rc(12'h2fc, 32'h0);
        $display("test readonly done");
        for (int i = 0; i < 12; i++) begin
            lf = nxt(lf);
            v = (i < 4) ? cv[i] : lf[7:0];
            wb(12'h210, 1'b1, 4'h1, {lf[31:8], v});
            rc(12'h214, exp_data(v, 8'h04));
            rc(12'h210, {24'h0, v});
            chk({24'h0, osel}, {24'h0, v});
        end
        wb(12'h210, 1'b1, 4'he, 32'h55);
        rc(12'h210, {24'h0, v});
        $display("test selector done");
        lf = nxt(lf);
        @(posedge i_ref_clk);
        ld <= 1'b1;
        bp <= lf[7:0];
        sa <= 1'b1;
        @(posedge i_ref_clk);
        ld <= 1'b0;
        wb(12'h210, 1'b1, 4'h1, 32'h0);
        rc(12'h214, exp_data(8'h00, lf[7:0]));
        rc(12'h218, 32'h1);
        // a load pulse while frozen must not be captured
        @(posedge i_ref_clk);
        ce <= 1'b0;
        ld <= 1'b1;
        bp <= ~lf[7:0];
        sa <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        ce <= 1'b1;
        ld <= 1'b0;
        rc(12'h214, exp_data(8'h00, lf[7:0]));
        rc(12'h218, 32'h1);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rc(12'h214, 32'h000b_8004);
        rc(12'h218, 32'h0);
        $display("test load done");
        tally_and_finish();
    end
endmodule : power_budget_capability_tb_top
`default_nettype wire
